/* File: logic/pic_top.v */
// Prioritised interrupt controller with AXI4-Lite register access
`timescale 1ns/1ps
`default_nettype none
`include "pic_regs.vh"
module pic_top (
	input wire aclk,
	input wire aresetn,
	input wire [7:0] s_axil_awaddr,
	input wire s_axil_awvalid,
	output wire s_axil_awready,
	input wire [31:0] s_axil_wdata,
	input wire [3:0] s_axil_wstrb,
	input wire s_axil_wvalid,
	output wire s_axil_wready,
	output reg [1:0] s_axil_bresp,
	output reg s_axil_bvalid,
	input wire s_axil_bready,
	input wire [7:0] s_axil_araddr,
	input wire s_axil_arvalid,
	output wire s_axil_arready,
	output reg [31:0] s_axil_rdata,
	output reg [1:0] s_axil_rresp,
	output reg s_axil_rvalid,
	input wire s_axil_rready,
	input wire power_low,
	input wire [5:0] ext_pin_n,
	input wire timer0_ovf,
	input wire timer1_ovf,
	input wire timer2_ovf,
	input wire timer2_pin,
	input wire serial0_rx,
	input wire serial0_tx,
	input wire serial1_rx,
	input wire serial1_tx,
	input wire watchdog_tmo,
	output reg irq_req,
	output reg [7:0] irq_vector,
	output reg [3:0] irq_src,
	input wire irq_ack,
	input wire irq_reti
);
	reg [7:0] int_enable_reg;
	reg [7:0] upper_int_enable_reg;
	reg [7:0] low_priority_reg;
	reg [7:0] high_priority_reg;
	reg [7:0] upper_low_priority_reg;
	reg [7:0] upper_high_priority_reg;
	reg it0;
	reg it1;
	reg timer0_overflow_flag;
	reg timer1_overflow_flag;
	reg timer2_overflow_flag;
	reg timer2_pin_flag;
	reg serial0_rx_flag;
	reg serial0_tx_flag;
	reg serial1_rx_flag;
	reg serial1_tx_flag;
	reg watchdog_irq_flag;
	reg power_fail_flag;
	reg power_fail_irq_enable;
	reg [5:0] pin_flag;
	reg [5:0] pin_prev;
	reg power_prev;
	reg [2:0] irq_lvl;
	reg aw_held;
	reg w_held;
	reg [7:0] aw_addr;
	reg [7:0] w_data;
	reg w_lane0;
	reg [7:0] rd_byte;
	reg rd_ok;
	reg [7:0] next_vector;
	wire wr_fire;
	wire wr_en;
	wire wr_ok;
	wire ack_t0;
	wire ack_t1;
	wire wr_timer_control_reg;
	wire wr_upper_flag_reg;
	wire wr_wdc;
	wire wr_ser;
	wire [5:0] pin_wr;
	wire [5:0] pin_wd;
	wire [5:0] pin_mode_edge;
	wire [5:0] pin_ack;
	wire [5:0] pin_fall;
	wire power_drop;
	wire [12:0] pend;
	wire [12:0] en;
	wire [11:0] hi;
	wire [11:0] lo;
	wire win_valid;
	wire [3:0] win_idx;
	wire [2:0] win_lvl;
	wire [4:0] active;
	wire cur_valid;
	wire [2:0] cur_lvl;
	wire take;

	// Register bus: address and data may arrive in either order
	assign s_axil_awready = ~aw_held;
	assign s_axil_wready = ~w_held;
	assign s_axil_arready = ~s_axil_rvalid;
	assign wr_fire = aw_held & w_held & ~s_axil_bvalid;
	assign wr_ok = aw_addr <= `PIC_OFF_SER && aw_addr[1:0] == 2'h0;
	// Only byte lane 0 carries register bits, so writes without it leave state alone
	assign wr_en = wr_fire & wr_ok & w_lane0;

	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 8'h00;
			w_lane0 <= 1'b0;
			s_axil_bvalid <= 1'b0;
			s_axil_bresp <= `PIC_RESP_OKAY;
		end
		else
		begin
			if (s_axil_awvalid && !aw_held)
			begin
				aw_held <= 1'b1;
				aw_addr <= s_axil_awaddr;
			end
			else if (wr_fire)
				aw_held <= 1'b0;
			if (s_axil_wvalid && !w_held)
			begin
				w_held <= 1'b1;
				w_data <= s_axil_wdata[7:0];
				w_lane0 <= s_axil_wstrb[0];
			end
			else if (wr_fire)
				w_held <= 1'b0;
			if (wr_fire)
			begin
				s_axil_bvalid <= 1'b1;
				s_axil_bresp <= wr_ok ? `PIC_RESP_OKAY : `PIC_RESP_SLVERR;
			end
			else if (s_axil_bready)
				s_axil_bvalid <= 1'b0;
		end
	end

	// Status word shows the in-service levels and the offered vector
	always @*
	begin
		rd_ok = 1'b1;
		rd_byte = 8'h00;
		case (s_axil_araddr)
			`PIC_OFF_IE: rd_byte = int_enable_reg;
			`PIC_OFF_EIE: rd_byte = upper_int_enable_reg;
			`PIC_OFF_LP: rd_byte = low_priority_reg;
			`PIC_OFF_HP: rd_byte = high_priority_reg;
			`PIC_OFF_ELP: rd_byte = upper_low_priority_reg;
			`PIC_OFF_EHP: rd_byte = upper_high_priority_reg;
			`PIC_OFF_TIMER_CONTROL_REG: rd_byte = {timer1_overflow_flag, 1'b0, timer0_overflow_flag, 1'b0,
				pin_flag[1], it1, pin_flag[0], it0};
			`PIC_OFF_UPPER_FLAG_REG: rd_byte = {pin_flag[5:2], 4'h0};
			`PIC_OFF_WDC: rd_byte = {2'h0, power_fail_irq_enable, power_fail_flag,
				watchdog_irq_flag, 3'h0};
			`PIC_OFF_SER: rd_byte = {2'h0, timer2_pin_flag, timer2_overflow_flag,
				serial1_tx_flag, serial1_rx_flag, serial0_tx_flag, serial0_rx_flag};
			`PIC_OFF_STAT: rd_byte = 8'h00;
			default: rd_ok = 1'b0;
		endcase
	end

	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axil_rvalid <= 1'b0;
			s_axil_rdata <= 32'h00000000;
			s_axil_rresp <= `PIC_RESP_OKAY;
		end
		else if (s_axil_arvalid && !s_axil_rvalid)
		begin
			s_axil_rvalid <= 1'b1;
			s_axil_rresp <= rd_ok ? `PIC_RESP_OKAY : `PIC_RESP_SLVERR;
			if (s_axil_araddr == `PIC_OFF_STAT)
				s_axil_rdata <= {8'h00, irq_vector, 4'h0, irq_src, 3'h0, active};
			else
				s_axil_rdata <= {24'h000000, rd_byte};
		end
		else if (s_axil_rready)
			s_axil_rvalid <= 1'b0;
	end

	// Enable and priority registers steer the resolver
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			int_enable_reg <= `PIC_REG_RESET;
			upper_int_enable_reg <= `PIC_REG_RESET;
			low_priority_reg <= `PIC_REG_RESET;
			high_priority_reg <= `PIC_REG_RESET;
			upper_low_priority_reg <= `PIC_REG_RESET;
			upper_high_priority_reg <= `PIC_REG_RESET;
			it0 <= 1'b0;
			it1 <= 1'b0;
			power_fail_irq_enable <= 1'b0;
		end
		else if (wr_en)
		begin
			case (aw_addr)
				`PIC_OFF_IE: int_enable_reg <= w_data;
				`PIC_OFF_EIE: upper_int_enable_reg <= {3'h0, w_data[4:0]};
				`PIC_OFF_LP: low_priority_reg <= {1'b0, w_data[6:0]};
				`PIC_OFF_HP: high_priority_reg <= {1'b0, w_data[6:0]};
				`PIC_OFF_ELP: upper_low_priority_reg <= {3'h0, w_data[4:0]};
				`PIC_OFF_EHP: upper_high_priority_reg <= {3'h0, w_data[4:0]};
				`PIC_OFF_TIMER_CONTROL_REG:
				begin
					it0 <= w_data[`PIC_TIMER_CONTROL_REG_IT0];
					it1 <= w_data[`PIC_TIMER_CONTROL_REG_IT1];
				end
				`PIC_OFF_WDC: power_fail_irq_enable <= w_data[`PIC_WDC_PFE];
				default: it0 <= it0;
			endcase
		end
	end

	// Source conditions
	assign pin_fall = pin_prev & ~ext_pin_n;
	assign power_drop = power_low & ~power_prev;
	assign take = irq_req & irq_ack;
	assign ack_t0 = take && irq_src == `PIC_SRC_T0;
	assign ack_t1 = take && irq_src == `PIC_SRC_T1;
	assign wr_timer_control_reg = wr_en && aw_addr == `PIC_OFF_TIMER_CONTROL_REG;
	assign wr_upper_flag_reg = wr_en && aw_addr == `PIC_OFF_UPPER_FLAG_REG;
	assign wr_wdc = wr_en && aw_addr == `PIC_OFF_WDC;
	assign wr_ser = wr_en && aw_addr == `PIC_OFF_SER;
	assign pin_wr = {{4{wr_upper_flag_reg}}, wr_timer_control_reg, wr_timer_control_reg};
	assign pin_wd = {w_data[7:`PIC_UPPER_FLAG_REG_PIN2F], w_data[`PIC_TIMER_CONTROL_REG_PIN1F],
		w_data[`PIC_TIMER_CONTROL_REG_PIN0F]};
	assign pin_mode_edge = {4'hF, it1, it0};
	assign pin_ack = {4'h0, take && irq_src == `PIC_SRC_X1, take && irq_src == `PIC_SRC_X0};

	genvar p;
	generate
		for (p = 0; p < 6; p = p + 1)
		begin : g_pin
			always @(posedge aclk)
			begin
				if (!aresetn)
				begin
					pin_prev[p] <= 1'b1;
					pin_flag[p] <= 1'b0;
				end
				else
				begin
					pin_prev[p] <= ext_pin_n[p];
					if (!pin_mode_edge[p])
						pin_flag[p] <= ~ext_pin_n[p];
					// vectoring clears the pin 0 and pin 1 edge flags only, a new edge still wins
					else
						pin_flag[p] <= (pin_wr[p] ? pin_wd[p] : pin_flag[p] & ~pin_ack[p])
							| pin_fall[p];
				end
			end
		end
	endgenerate

	// flags set regardless of enables, and a set beats any clear
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			timer0_overflow_flag <= 1'b0;
			timer1_overflow_flag <= 1'b0;
			timer2_overflow_flag <= 1'b0;
			timer2_pin_flag <= 1'b0;
			serial0_rx_flag <= 1'b0;
			serial0_tx_flag <= 1'b0;
			serial1_rx_flag <= 1'b0;
			serial1_tx_flag <= 1'b0;
			watchdog_irq_flag <= 1'b0;
			power_fail_flag <= 1'b0;
			power_prev <= 1'b0;
		end
		else
		begin
			power_prev <= power_low;
			timer0_overflow_flag <= (wr_timer_control_reg ? w_data[`PIC_TIMER_CONTROL_REG_TF0] :
				timer0_overflow_flag & ~ack_t0) | timer0_ovf;
			timer1_overflow_flag <= (wr_timer_control_reg ? w_data[`PIC_TIMER_CONTROL_REG_TF1] :
				timer1_overflow_flag & ~ack_t1) | timer1_ovf;
			// these flags are cleared only by software writes, not by vectoring
			timer2_overflow_flag <= (wr_ser ? w_data[`PIC_SER_T2OVF] :
				timer2_overflow_flag) | timer2_ovf;
			timer2_pin_flag <= (wr_ser ? w_data[`PIC_SER_T2PIN] : timer2_pin_flag)
				| timer2_pin;
			serial0_rx_flag <= (wr_ser ? w_data[`PIC_SER_S0RX] : serial0_rx_flag)
				| serial0_rx;
			serial0_tx_flag <= (wr_ser ? w_data[`PIC_SER_S0TX] : serial0_tx_flag)
				| serial0_tx;
			serial1_rx_flag <= (wr_ser ? w_data[`PIC_SER_S1RX] : serial1_rx_flag)
				| serial1_rx;
			serial1_tx_flag <= (wr_ser ? w_data[`PIC_SER_S1TX] : serial1_tx_flag)
				| serial1_tx;
			watchdog_irq_flag <= (wr_wdc ? w_data[`PIC_WDC_WDF] : watchdog_irq_flag)
				| watchdog_tmo;
			// sticky on each drop below the warning level
			power_fail_flag <= (wr_wdc ? w_data[`PIC_WDC_PFF] : power_fail_flag)
				| power_drop;
		end
	end

	assign pend = {watchdog_irq_flag, pin_flag[5:2], serial1_rx_flag | serial1_tx_flag,
		timer2_overflow_flag | timer2_pin_flag, serial0_rx_flag | serial0_tx_flag,
		timer1_overflow_flag, pin_flag[1], timer0_overflow_flag, pin_flag[0],
		power_fail_flag};
	assign en = {upper_int_enable_reg[4:0], int_enable_reg[6:0], power_fail_irq_enable};
	assign lo = {upper_low_priority_reg[4:0], low_priority_reg[6:0]};
	assign hi = {upper_high_priority_reg[4:0], high_priority_reg[6:0]};

	// global enable gates all but power-fail
	pic_arb u_arb (
		.pend(pend),
		.en(en),
		.global_en(int_enable_reg[`PIC_IE_GLOBAL]),
		.hi(hi),
		.lo(lo),
		.cur_valid(cur_valid),
		.cur_lvl(cur_lvl),
		.win_valid(win_valid),
		.win_idx(win_idx),
		.win_lvl(win_lvl)
	);

	pic_stack u_stack (
		.aclk(aclk),
		.aresetn(aresetn),
		.push(take),
		.push_lvl(irq_lvl),
		.pop(irq_reti),
		.active(active),
		.cur_valid(cur_valid),
		.cur_lvl(cur_lvl)
	);

	always @*
	begin
		case (win_idx)
			4'h0: next_vector = `PIC_VEC_PF;
			4'h1: next_vector = `PIC_VEC_X0;
			4'h2: next_vector = `PIC_VEC_T0;
			4'h3: next_vector = `PIC_VEC_X1;
			4'h4: next_vector = `PIC_VEC_T1;
			4'h5: next_vector = `PIC_VEC_S0;
			4'h6: next_vector = `PIC_VEC_T2;
			4'h7: next_vector = `PIC_VEC_S1;
			4'h8: next_vector = `PIC_VEC_X2;
			4'h9: next_vector = `PIC_VEC_X3;
			4'hA: next_vector = `PIC_VEC_X4;
			4'hB: next_vector = `PIC_VEC_X5;
			default: next_vector = `PIC_VEC_WD;
		endcase
	end

	// Request drops for one cycle after an ack so the new in-service level settles
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			irq_req <= 1'b0;
			irq_vector <= 8'h00;
			irq_src <= 4'h0;
			irq_lvl <= 3'h0;
		end
		else
		begin
			// only a strictly higher level is offered
			irq_req <= win_valid & ~take & ~irq_reti;
			irq_vector <= next_vector;
			irq_src <= win_idx;
			irq_lvl <= win_lvl;
		end
	end
endmodule
`default_nettype wire

/* File: logic/pic_regs.vh */
// Register map, field positions, vectors and levels of the interrupt controller
`ifndef PIC_REGS_VH
`define PIC_REGS_VH
`define PIC_NSRC 13
`define PIC_OFF_IE 8'h00
`define PIC_OFF_EIE 8'h04
`define PIC_OFF_LP 8'h08
`define PIC_OFF_HP 8'h0C
`define PIC_OFF_ELP 8'h10
`define PIC_OFF_EHP 8'h14
`define PIC_OFF_TIMER_CONTROL_REG 8'h18
`define PIC_OFF_UPPER_FLAG_REG 8'h1C
`define PIC_OFF_WDC 8'h20
`define PIC_OFF_SER 8'h24
`define PIC_OFF_STAT 8'h28
`define PIC_IE_GLOBAL 7
`define PIC_TIMER_CONTROL_REG_IT0 0
`define PIC_TIMER_CONTROL_REG_PIN0F 1
`define PIC_TIMER_CONTROL_REG_IT1 2
`define PIC_TIMER_CONTROL_REG_PIN1F 3
`define PIC_TIMER_CONTROL_REG_TF0 5
`define PIC_TIMER_CONTROL_REG_TF1 7
`define PIC_UPPER_FLAG_REG_PIN2F 4
`define PIC_WDC_WDF 3
`define PIC_WDC_PFF 4
`define PIC_WDC_PFE 5
`define PIC_SER_S0RX 0
`define PIC_SER_S0TX 1
`define PIC_SER_S1RX 2
`define PIC_SER_S1TX 3
`define PIC_SER_T2OVF 4
`define PIC_SER_T2PIN 5
`define PIC_REG_RESET 8'h00
`define PIC_PF_LEVEL 3'h4
`define PIC_RESP_OKAY 2'h0
`define PIC_RESP_SLVERR 2'h2
`define PIC_SRC_PF 4'h0
`define PIC_SRC_X0 4'h1
`define PIC_SRC_T0 4'h2
`define PIC_SRC_X1 4'h3
`define PIC_SRC_T1 4'h4
`define PIC_VEC_PF 8'h33
`define PIC_VEC_X0 8'h03
`define PIC_VEC_T0 8'h0B
`define PIC_VEC_X1 8'h13
`define PIC_VEC_T1 8'h1B
`define PIC_VEC_S0 8'h23
`define PIC_VEC_T2 8'h2B
`define PIC_VEC_S1 8'h3B
`define PIC_VEC_X2 8'h43
`define PIC_VEC_X3 8'h4B
`define PIC_VEC_X4 8'h53
`define PIC_VEC_X5 8'h5B
`define PIC_VEC_WD 8'h63
`endif

/* File: logic/pic_arb.v */
// Priority resolver: gating, level per source, natural order tie break
`timescale 1ns/1ps
`default_nettype none
`include "pic_regs.vh"
module pic_arb (
	input wire [12:0] pend,
	input wire [12:0] en,
	input wire global_en,
	input wire [11:0] hi,
	input wire [11:0] lo,
	input wire cur_valid,
	input wire [2:0] cur_lvl,
	output wire win_valid,
	output reg [3:0] win_idx,
	output reg [2:0] win_lvl
);
	wire [12:0] req;
	wire [38:0] lvl_flat;
	reg found;
	integer j;
	genvar i;
	generate
		for (i = 0; i < `PIC_NSRC; i = i + 1)
		begin : g_src
			if (i == 0)
			begin : g_pf
				assign req[i] = pend[i] & en[i];
				assign lvl_flat[2:0] = `PIC_PF_LEVEL;
			end
			else
			begin : g_std
				assign req[i] = pend[i] & en[i] & global_en;
				assign lvl_flat[3*i+2:3*i] = {1'b0, hi[i-1], lo[i-1]};
			end
		end
	endgenerate
	// scanning downward lets the earliest source win a tie
	always @*
	begin
		found = 1'b0;
		win_idx = 4'h0;
		win_lvl = 3'h0;
		for (j = `PIC_NSRC - 1; j >= 0; j = j - 1)
		begin
			if (req[j] && (!found || lvl_flat[3*j+:3] >= win_lvl))
			begin
				found = 1'b1;
				win_idx = j[3:0];
				win_lvl = lvl_flat[3*j+:3];
			end
		end
	end
	// strictly higher than the running handler
	assign win_valid = found && (!cur_valid || win_lvl > cur_lvl);
endmodule
`default_nettype wire

/* File: logic/pic_stack.v */
// In-service level tracker: one bit per level, cleared on return
`timescale 1ns/1ps
`default_nettype none
module pic_stack (
	input wire aclk,
	input wire aresetn,
	input wire push,
	input wire [2:0] push_lvl,
	input wire pop,
	output reg [4:0] active,
	output reg cur_valid,
	output reg [2:0] cur_lvl
);
	integer k;
	wire [4:0] pop_mask;
	wire [4:0] push_mask;
	assign pop_mask = (pop && cur_valid) ? (5'h01 << cur_lvl) : 5'h00;
	assign push_mask = push ? (5'h01 << push_lvl) : 5'h00;
	always @*
	begin
		cur_valid = 1'b0;
		cur_lvl = 3'h0;
		for (k = 0; k < 5; k = k + 1)
		begin
			if (active[k])
			begin
				cur_valid = 1'b1;
				cur_lvl = k[2:0];
			end
		end
	end
	// return ends the highest running level first
	always @(posedge aclk)
	begin
		if (!aresetn)
			active <= 5'h00;
		else
			active <= (active & ~pop_mask) | push_mask;
	end
endmodule
`default_nettype wire

/* File: dv/pic_top_properties.sv */
// Port checker for the interrupt controller, bound to its top
`timescale 1ns/1ps
`default_nettype none
module pic_top_props (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axil_awvalid,
	input wire logic s_axil_awready,
	input wire logic s_axil_wvalid,
	input wire logic s_axil_wready,
	input wire logic [1:0] s_axil_bresp,
	input wire logic s_axil_bvalid,
	input wire logic s_axil_bready,
	input wire logic s_axil_arvalid,
	input wire logic s_axil_arready,
	input wire logic [31:0] s_axil_rdata,
	input wire logic s_axil_rvalid,
	input wire logic s_axil_rready,
	input wire logic irq_req,
	input wire logic [7:0] irq_vector,
	input wire logic [3:0] irq_src,
	input wire logic irq_ack,
	input wire logic irq_reti
);
	// Vectors in natural order, source 0 in the low byte
	localparam logic [103:0] VT = {8'h63, 8'h5B, 8'h53, 8'h4B, 8'h43, 8'h3B,
		8'h2B, 8'h23, 8'h1B, 8'h13, 8'h0B, 8'h03, 8'h33};
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	sequence s_wr;
		s_axil_awvalid && s_axil_awready && s_axil_wvalid && s_axil_wready;
	endsequence
	sequence s_take;
		irq_req && irq_ack;
	endsequence
	// Both parts are held for one edge before the write fires and raises bvalid
	property p_wr_ans;
		s_wr |-> ##2 s_axil_bvalid;
	endproperty
	a_wr_ans: assert property (p_wr_ans) else $error("write response missing");
	property p_b_hold;
		s_axil_bvalid && !s_axil_bready |=> s_axil_bvalid && $stable(s_axil_bresp);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write response dropped");
	property p_rd_ans;
		s_axil_arvalid && s_axil_arready |=> s_axil_rvalid;
	endproperty
	a_rd_ans: assert property (p_rd_ans) else $error("read data missing");
	property p_r_hold;
		s_axil_rvalid && !s_axil_rready |=> s_axil_rvalid && $stable(s_axil_rdata);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read data dropped");
	property p_ar_busy;
		s_axil_rvalid |-> !s_axil_arready;
	endproperty
	a_ar_busy: assert property (p_ar_busy) else $error("address taken while busy");
	property p_src_rng;
		irq_req |-> irq_src < 4'hD;
	endproperty
	a_src_rng: assert property (p_src_rng) else $error("source out of range");
	property p_vec;
		irq_req && irq_src < 4'hD |-> irq_vector == VT[{irq_src, 3'h0} +: 8];
	endproperty
	a_vec: assert property (p_vec) else $error("vector mismatch");
	property p_ack;
		s_take |=> !irq_req;
	endproperty
	a_ack: assert property (p_ack) else $error("request held after ack");
	property p_reti;
		irq_reti |=> !irq_req;
	endproperty
	a_reti: assert property (p_reti) else $error("request right after return");
endmodule
bind pic_top pic_top_props pic_top_props_i (.aclk, .aresetn, .s_axil_awvalid,
	.s_axil_awready, .s_axil_wvalid, .s_axil_wready, .s_axil_bresp, .s_axil_bvalid,
	.s_axil_bready, .s_axil_arvalid, .s_axil_arready, .s_axil_rdata, .s_axil_rvalid,
	.s_axil_rready, .irq_req, .irq_vector, .irq_src, .irq_ack, .irq_reti);
`default_nettype wire

/* File: dv/pic_core_model.sv */
// Behavioural core: takes vectors after a set delay, returns on command
`timescale 1ns/1ps
`default_nettype none
module pic_core_model (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic irq_req,
	input wire logic [7:0] irq_vector,
	input wire logic en,
	input wire logic [3:0] dly,
	input wire logic do_ret,
	output logic irq_ack,
	output logic irq_reti,
	output logic [7:0] last_vec,
	output logic [7:0] n_ack
);
	logic [3:0] cnt;
	always @(posedge aclk)
	begin
		irq_ack <= 1'b0;
		irq_reti <= do_ret;
		if (!aresetn)
		begin
			cnt <= 4'h0;
			n_ack <= 8'h00;
			last_vec <= 8'h00;
		end
		// Ack only while a request stands, never twice
		else if (en && irq_req && !irq_ack)
		begin
			cnt <= cnt + 4'h1;
			if (cnt >= dly)
			begin
				irq_ack <= 1'b1;
				last_vec <= irq_vector;
				n_ack <= n_ack + 8'h01;
				cnt <= 4'h0;
			end
		end
		else
			cnt <= 4'h0;
	end
endmodule
`default_nettype wire

/* File: dv/prioritized_interrupt_controller_tb.sv */
// Self-checking bench for the interrupt controller with a core model
`timescale 1ns/1ps
`default_nettype none
module prioritized_interrupt_controller_tb;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic power_low = 1'b0;
	logic [5:0] ext_pin_n = 6'h3F;
	logic [8:0] ev = 9'h000;
	logic en = 1'b1;
	logic [3:0] dly = 4'h0;
	logic do_ret = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, irq_req, irq_ack, irq_reti;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [7:0] irq_vector, last_vec, n_ack;
	logic [3:0] irq_src;
	int errors = 0;
	int tests_run = 0;
	int cycles = 0;
	always #25 aclk = ~aclk;
	pic_top pic_top_i (.aclk(aclk), .aresetn(aresetn), .s_axil_awaddr(awaddr),
		.s_axil_awvalid(awvalid), .s_axil_awready(awready), .s_axil_wdata(wdata),
		.s_axil_wstrb(4'hF), .s_axil_wvalid(wvalid), .s_axil_wready(wready),
		.s_axil_bresp(bresp), .s_axil_bvalid(bvalid), .s_axil_bready(bready),
		.s_axil_araddr(araddr), .s_axil_arvalid(arvalid), .s_axil_arready(arready),
		.s_axil_rdata(rdata), .s_axil_rresp(rresp), .s_axil_rvalid(rvalid),
		.s_axil_rready(rready), .power_low(power_low), .ext_pin_n(ext_pin_n),
		.timer0_ovf(ev[0]), .timer1_ovf(ev[1]), .timer2_ovf(ev[2]), .timer2_pin(ev[3]),
		.serial0_rx(ev[4]), .serial0_tx(ev[5]), .serial1_rx(ev[6]), .serial1_tx(ev[7]),
		.watchdog_tmo(ev[8]), .irq_req(irq_req), .irq_vector(irq_vector),
		.irq_src(irq_src), .irq_ack(irq_ack), .irq_reti(irq_reti));
	pic_core_model pic_core_model_i (.aclk(aclk), .aresetn(aresetn), .irq_req(irq_req),
		.irq_vector(irq_vector), .en(en), .dly(dly), .do_ret(do_ret), .irq_ack(irq_ack),
		.irq_reti(irq_reti), .last_vec(last_vec), .n_ack(n_ack));
	task automatic stop_test;
		$display("errors %0d tests_run %0d", errors, tests_run);
		if (errors == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	always @(posedge aclk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			errors++;
			stop_test();
		end
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e)
		begin
			errors++;
			$display("wrong value at %0t: %h expected %h", $time, g, e);
		end
	endtask
	// Ready is sampled mid-cycle, where it has settled since the last edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		logic da, dw;
		da = 1'b0;
		dw = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(da && dw))
		begin
			@(negedge aclk);
			da = da || (awvalid && awready);
			dw = dw || (wvalid && wready);
			@(posedge aclk);
			if (da)
				awvalid <= 1'b0;
			if (dw)
				wvalid <= 1'b0;
		end
		@(negedge aclk);
		while (bvalid !== 1'b1)
			@(negedge aclk);
		chk(bresp, r);
		@(posedge aclk);
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		@(negedge aclk);
		while (arready !== 1'b1)
			@(negedge aclk);
		@(posedge aclk);
		arvalid <= 1'b0;
		@(negedge aclk);
		while (rvalid !== 1'b1)
			@(negedge aclk);
		chk(rdata, e);
		chk(rresp, r);
		@(posedge aclk);
		rready <= 1'b0;
	endtask
	task automatic wack(input logic [7:0] n);
		@(negedge aclk);
		while (n_ack !== n)
			@(negedge aclk);
	endtask
	task automatic ret;
		@(posedge aclk);
		do_ret <= 1'b1;
		@(posedge aclk);
		do_ret <= 1'b0;
	endtask
	task automatic t_regs;
		for (int i = 0; i < 10; i++)
			rd(8'(i * 4), 32'h0, 2'h0);
		// Idle status still shows the vector of source 0, the first in natural order
		rd(8'h28, 32'h00330000, 2'h0);
		rd(8'h2C, 32'h0, 2'h2);
		wr(8'h28, 32'h1, 2'h2);
		wr(8'h08, 32'h7F, 2'h0);
		rd(8'h08, 32'h7F, 2'h0);
		wr(8'h08, 32'h0, 2'h0);
	endtask
	task automatic t_gate;
		wr(8'h00, 32'h02, 2'h0);
		@(posedge aclk);
		ev <= 9'h001;
		@(posedge aclk);
		ev <= 9'h000;
		repeat (4) @(negedge aclk);
		chk(irq_req, 1'b0);
		rd(8'h18, 32'h20, 2'h0);
		wr(8'h00, 32'h82, 2'h0);
		wack(8'h01);
		chk(last_vec, 8'h0B);
		rd(8'h18, 32'h0, 2'h0);
		ret();
	endtask
	task automatic t_pf;
		wr(8'h00, 32'h02, 2'h0);
		wr(8'h20, 32'h20, 2'h0);
		@(posedge aclk);
		power_low <= 1'b1;
		wack(8'h02);
		chk(last_vec, 8'h33);
		rd(8'h20, 32'h30, 2'h0);
		wr(8'h20, 32'h20, 2'h0);
		rd(8'h20, 32'h20, 2'h0);
		@(posedge aclk);
		power_low <= 1'b0;
		ret();
	endtask
	task automatic t_order;
		@(posedge aclk);
		en <= 1'b0;
		wr(8'h18, 32'h05, 2'h0);
		wr(8'h00, 32'hFF, 2'h0);
		wr(8'h04, 32'h1F, 2'h0);
		wr(8'h10, 32'h10, 2'h0);
		wr(8'h14, 32'h10, 2'h0);
		@(posedge aclk);
		ext_pin_n <= 6'h00;
		ev <= 9'h16B;
		@(posedge aclk);
		ext_pin_n <= 6'h3F;
		ev <= 9'h000;
		repeat (3) @(negedge aclk);
		chk(irq_vector, 8'h63);
		chk(irq_src, 4'hC);
		rd(8'h24, 32'h26, 2'h0);
		rd(8'h1C, 32'hF0, 2'h0);
		@(posedge aclk);
		en <= 1'b1;
		dly <= 4'h3;
		wack(8'h03);
		chk(last_vec, 8'h63);
		wr(8'h20, 32'h0, 2'h0);
		repeat (8) @(negedge aclk);
		chk(irq_req, 1'b0);
		ret();
		wack(8'h04);
		chk(last_vec, 8'h03);
		rd(8'h18, 32'hAD, 2'h0);
		ret();
		wack(8'h05);
		chk(last_vec, 8'h0B);
		wr(8'h00, 32'h0, 2'h0);
		ret();
	endtask
	task automatic t_level;
		wr(8'h18, 32'h0, 2'h0);
		@(posedge aclk);
		ext_pin_n <= 6'h3E;
		rd(8'h18, 32'h02, 2'h0);
		@(posedge aclk);
		ext_pin_n <= 6'h3F;
		rd(8'h18, 32'h0, 2'h0);
	endtask
	initial
	begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs();
		t_gate();
		t_pf();
		t_order();
		t_level();
		stop_test();
	end
endmodule
`default_nettype wire
